// ==== ibesf_bus_model.sv ====
// Partner model: a master driving the two-wire bus lines
module ibesf_bus_model (
  // Clock
  input  wire logic sys_clk,
  // Bus lines, idle high by pull-up
  output logic      clock_line_pin,
  output logic      data_line_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Lines start released
  initial begin
    clock_line_pin = 1'b1;
    data_line_pin  = 1'b1;
  end

  // Wait whole system cycles
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : w

  // Start: data falls while clock is high
  task automatic start_c();
    data_line_pin <= 1'b1;
    w(4);
    clock_line_pin <= 1'b1;
    w(4);
    data_line_pin <= 1'b0;
    w(8);
    clock_line_pin <= 1'b0;
    w(4);
  endtask : start_c

  // Stop: data rises while clock is high
  task automatic stop_c();
    data_line_pin <= 1'b0;
    w(4);
    clock_line_pin <= 1'b1;
    w(4);
    data_line_pin <= 1'b1;
    w(8);
  endtask : stop_c

  // Bits msb first, 200 ns per bit, data stable around each clock rise
  task automatic send(input logic [8:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      data_line_pin <= v[8-i];
      w(2);
      clock_line_pin <= 1'b1;
      w(4);
      clock_line_pin <= 1'b0;
      w(2);
    end
  endtask : send
endmodule : ibesf_bus_model

// ==== ibesf_pkg.sv ====
// Package: constants and types of the bus event status flags block
package ibesf_pkg;

  // Register bus widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h1;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h2;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h3;

  // Control field positions
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_EXIT_BIT   = 6;

  // Flag field positions, shared by status, irq status and mask
  localparam int FLAG_STOP_BIT  = 0;
  localparam int FLAG_START_BIT = 1;
  localparam int FLAG_ACK_BIT   = 2;
  localparam int FLAG_W         = 3;

  // Reset values
  localparam logic       ENABLE_RST = 1'b0;
  localparam logic [2:0] FLAGS_RST  = 3'h0;
  localparam logic [2:0] MASK_RST   = 3'h0;
  localparam logic [7:0] RDATA_RST  = 8'h00;
  localparam logic [1:0] PIN_RST    = 2'h3;
  localparam logic [2:0] SYNC_RST   = 3'h7;

  // Clock counts within one byte on the clock line
  localparam logic [3:0] CNT_FIRST = 4'h0;
  localparam logic [3:0] CNT_EIGHT = 4'h8;
  localparam logic [3:0] CNT_NINE  = 4'h9;
  localparam logic [3:0] CNT_ONE   = 4'h1;

  // Bus event flags, ack in bit 2 down to stop in bit 0
  typedef struct packed {
    logic ack;
    logic start;
    logic stop;
  } ibesf_flags_t;

  // One register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ibesf_req_t;

  // Transfer phase on the bus
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_ADDR = 3'b010,
    PH_DATA = 3'b100
  } ibesf_phase_t;

endpackage : ibesf_pkg

// ==== ibesf_top.sv ====
// Module: two-wire bus event status flags with register port and interrupt
//
// The register offsets and strobed register access were decided locally.

module ibesf_top (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // Register port
  input  wire logic [ibesf_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ibesf_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [ibesf_pkg::DATA_W-1:0] reg_rdata,
  // Two-wire bus lines, observed only
  input  wire logic                     clock_line_pin,
  input  wire logic                     data_line_pin,
  // Flags and interrupt
  output ibesf_pkg::ibesf_flags_t       bus_event_status,
  output logic                          irq
);

  // Request bundle
  ibesf_pkg::ibesf_req_t req;
  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  // Pin synchronisers, bit 0 clock line, bit 1 data line
  logic [1:0] pin_raw;
  logic [1:0] pin_filt;
  assign pin_raw = {data_line_pin, clock_line_pin};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic [2:0] stage_q;
    logic       filt_q;
    // Three stages, change taken when last two agree
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        stage_q <= ibesf_pkg::SYNC_RST;
        filt_q  <= ibesf_pkg::PIN_RST[i];
      end else begin
        stage_q <= {stage_q[1:0], pin_raw[i]};
        if (stage_q[1] == stage_q[2]) begin
          filt_q <= stage_q[2];
        end
      end
    end
    assign pin_filt[i] = filt_q;
  end

  // Previous filtered levels
  logic [1:0] pin_prev_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_prev_q <= ibesf_pkg::PIN_RST;
    end else begin
      pin_prev_q <= pin_filt;
    end
  end

  // Control and state registers
  logic                     en_q;
  logic                     en_d;
  ibesf_pkg::ibesf_flags_t  flags_q;
  ibesf_pkg::ibesf_flags_t  flags_d;
  ibesf_pkg::ibesf_flags_t  irq_stat_q;
  ibesf_pkg::ibesf_flags_t  irq_stat_d;
  ibesf_pkg::ibesf_flags_t  mask_q;
  ibesf_pkg::ibesf_flags_t  mask_d;
  ibesf_pkg::ibesf_phase_t  phase_q;
  ibesf_pkg::ibesf_phase_t  phase_d;
  logic [3:0]               cnt_q;
  logic [3:0]               cnt_d;
  logic [7:0]               rdata_q;
  logic [7:0]               rdata_d;
  logic                     irq_q;
  logic                     irq_d;

  // Register write decode
  logic ctrl_wr;
  logic stat_wr;
  logic istat_wr;
  logic mask_wr;
  logic exit_req;
  logic en_fall;
  logic live;
  assign ctrl_wr  = req.wr && (req.addr == ibesf_pkg::OFS_CTRL);
  assign stat_wr  = req.wr && (req.addr == ibesf_pkg::OFS_STATUS);
  assign istat_wr = req.wr && (req.addr == ibesf_pkg::OFS_IRQ_STAT);
  assign mask_wr  = req.wr && (req.addr == ibesf_pkg::OFS_IRQ_MASK);
  assign exit_req = ctrl_wr && req.wdata[ibesf_pkg::CTRL_EXIT_BIT];
  assign en_fall  = ctrl_wr && en_q && !req.wdata[ibesf_pkg::CTRL_ENABLE_BIT];
  // Detection runs only while enabled and not being switched off
  assign live     = en_q && !en_fall;

  // Bus condition decode
  logic scl;
  logic sda;
  logic scl_prev;
  logic sda_prev;
  logic scl_rise;
  logic start_det;
  logic stop_det;
  assign scl       = pin_filt[0];
  assign sda       = pin_filt[1];
  assign scl_prev  = pin_prev_q[0];
  assign sda_prev  = pin_prev_q[1];
  assign scl_rise  = scl && !scl_prev;
  // Data falls while clock high
  assign start_det = live && scl && scl_prev && sda_prev && !sda;
  // Data rises while clock high
  assign stop_det  = live && scl && scl_prev && !sda_prev && sda;

  // Clock position within the byte
  logic rise_live;
  logic ack_clk;
  logic ack_set;
  logic next_byte;
  logic addr_first;
  logic addr_done;
  assign rise_live  = live && scl_rise && (phase_q != ibesf_pkg::PH_IDLE);
  assign ack_clk    = rise_live && (cnt_q == ibesf_pkg::CNT_EIGHT);
  assign ack_set    = ack_clk && !sda;
  assign next_byte  = rise_live && (cnt_q == ibesf_pkg::CNT_NINE);
  assign addr_first = rise_live && (phase_q == ibesf_pkg::PH_ADDR)
                      && (cnt_q == ibesf_pkg::CNT_FIRST);
  assign addr_done  = next_byte && (phase_q == ibesf_pkg::PH_ADDR);

  // Phase tracking
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      ibesf_pkg::PH_IDLE: begin
        if (start_det) begin
          phase_d = ibesf_pkg::PH_ADDR;
        end
      end
      ibesf_pkg::PH_ADDR: begin
        if (stop_det) begin
          phase_d = ibesf_pkg::PH_IDLE;
        end else if (next_byte) begin
          phase_d = ibesf_pkg::PH_DATA;
        end
      end
      ibesf_pkg::PH_DATA: begin
        if (stop_det) begin
          phase_d = ibesf_pkg::PH_IDLE;
        end else if (start_det) begin
          phase_d = ibesf_pkg::PH_ADDR;
        end
      end
      default: begin
        phase_d = ibesf_pkg::PH_IDLE;
      end
    endcase
    if (!live || (exit_req && !start_det)) begin
      phase_d = ibesf_pkg::PH_IDLE;
    end
  end

  // Clock counter, restarts on start, wraps nine to one
  always_comb begin
    cnt_d = cnt_q;
    if (start_det || !live) begin
      cnt_d = ibesf_pkg::CNT_FIRST;
    end else if (rise_live) begin
      cnt_d = (cnt_q == ibesf_pkg::CNT_NINE) ? ibesf_pkg::CNT_ONE
                                             : cnt_q + ibesf_pkg::CNT_ONE;
    end
  end

  // ack set, ack clear, set wins over exit request clear
  assign flags_d.ack   = ack_set
                         || (flags_q.ack && !(stop_det || next_byte || exit_req || en_fall));
  assign flags_d.start = start_det
                         || (flags_q.start && !(stop_det || addr_done || exit_req || en_fall));
  // stop set, stop clear ignores exit request
  assign flags_d.stop  = stop_det || (flags_q.stop && !(addr_first || en_fall));

  // Control and interrupt register next values
  assign en_d       = ctrl_wr ? req.wdata[ibesf_pkg::CTRL_ENABLE_BIT] : en_q;
  assign mask_d     = mask_wr ? req.wdata[ibesf_pkg::FLAG_W-1:0] : mask_q;
  // Events set sticky bits, write one clears, set wins
  assign irq_stat_d = {ack_set, start_det, stop_det}
                      | (irq_stat_q & ~(istat_wr ? req.wdata[ibesf_pkg::FLAG_W-1:0]
                                                 : ibesf_pkg::FLAGS_RST));
  assign irq_d      = |(irq_stat_d & mask_d);

  // Read mux, zero outside the cycle after a read
  logic [7:0] rd_mux;
  assign rd_mux =
    (req.addr == ibesf_pkg::OFS_CTRL)     ? {en_q, 7'h00} :
    (req.addr == ibesf_pkg::OFS_STATUS)   ? {5'h00, flags_q} :
    (req.addr == ibesf_pkg::OFS_IRQ_STAT) ? {5'h00, irq_stat_q} :
    (req.addr == ibesf_pkg::OFS_IRQ_MASK) ? {5'h00, mask_q} :
                                            ibesf_pkg::RDATA_RST;
  assign rdata_d = req.rd ? rd_mux : ibesf_pkg::RDATA_RST;

  // Control registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_q   <= ibesf_pkg::ENABLE_RST;
      mask_q <= ibesf_pkg::MASK_RST;
    end else begin
      en_q   <= en_d;
      mask_q <= mask_d;
    end
  end

  // flags move only by bus events, exit requests and disable writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_q <= ibesf_pkg::FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Bus tracking state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_q <= ibesf_pkg::PH_IDLE;
      cnt_q   <= ibesf_pkg::CNT_FIRST;
    end else begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
    end
  end

  // Interrupt and read data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_q <= ibesf_pkg::FLAGS_RST;
      irq_q      <= 1'b0;
      rdata_q    <= ibesf_pkg::RDATA_RST;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q      <= irq_d;
      rdata_q    <= rdata_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata        = rdata_q;
  assign bus_event_status = flags_q;
  assign irq              = irq_q;

  // Checks on the flag logic
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_ACK_SET: assert property (
    ack_clk && !sda |=> flags_q.ack && irq_stat_q.ack
  ) else $error("ack flag missed at ninth clock");

  AST_ACK_CLR: assert property (
    (stop_det || next_byte || exit_req || en_fall) && !ack_set |=> !flags_q.ack
  ) else $error("ack flag not cleared");

  AST_START_SET: assert property (
    start_det |=> flags_q.start && phase_q == ibesf_pkg::PH_ADDR
  ) else $error("start flag not set");

  AST_START_CLR: assert property (
    addr_done && !exit_req |=> !flags_q.start && phase_q == ibesf_pkg::PH_DATA
  ) else $error("start flag not cleared after address");

  AST_STOP_SET: assert property (
    stop_det |=> flags_q.stop && !flags_q.start && phase_q == ibesf_pkg::PH_IDLE
  ) else $error("stop flag not set");

  // stop clears at address first clock
  AST_STOP_CLR: assert property (
    addr_first && !stop_det |=> !flags_q.stop
  ) else $error("stop flag not cleared at address clock");

  AST_OFF_CLEAR: assert property (
    !en_q |-> flags_q == ibesf_pkg::FLAGS_RST
  ) else $error("flags set while unit disabled");

  AST_EXIT_KEEP: assert property (
    exit_req && flags_q.stop && !en_fall && !addr_first |=> flags_q.stop
  ) else $error("exit request cleared stop flag");

  AST_STATUS_RO: assert property (
    stat_wr && !(start_det || stop_det || rise_live || exit_req || en_fall)
    |=> $stable(flags_q)
  ) else $error("status write changed flags");

  // Read data only after a read
  AST_RDATA_IDLE: assert property (
    !req.rd |=> reg_rdata == ibesf_pkg::RDATA_RST
  ) else $error("read data outside read answer");

  // Interrupt follows masked status
  AST_IRQ: assert property (
    irq == |(irq_stat_q & mask_q)
  ) else $error("interrupt level wrong");

  // ack only from ninth clock low
  AST_ACK_SRC: assert property (
    $rose(flags_q.ack) |-> $past(ack_set)
  ) else $error("ack flag set without acknowledge");

  AST_OFF_FALL: assert property (
    en_fall |=> flags_q == ibesf_pkg::FLAGS_RST
  ) else $error("flags kept after disable");

  AST_START_SRC: assert property (
    $rose(flags_q.start) |-> $past(start_det)
  ) else $error("start flag set without start condition");

  AST_START_EXIT: assert property (
    exit_req && !start_det |=> !flags_q.start
  ) else $error("start flag kept after exit request");

  AST_STOP_SRC: assert property (
    $rose(flags_q.stop) |-> $past(stop_det)
  ) else $error("stop flag set without stop condition");

  // Main scenarios
  COV_ACK: cover property (ack_set);
  COV_ADDR_DONE: cover property (addr_done ##[1:1000] stop_det);
  COV_RESTART: cover property (phase_q == ibesf_pkg::PH_DATA && start_det);
  COV_STOP_CLR: cover property (flags_q.stop && addr_first);

endmodule : ibesf_top

// ==== ibesf_top_test.sv ====
// Testbench: bus event flags, register port and interrupt
module ibesf_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                           sys_clk = 1'b0;
  logic                           rst     = 1'b1;
  logic [ibesf_pkg::ADDR_W-1:0]   reg_addr  = 4'h0;
  logic [ibesf_pkg::DATA_W-1:0]   reg_wdata = 8'h00;
  logic                           reg_wr  = 1'b0;
  logic                           reg_rd  = 1'b0;
  logic [ibesf_pkg::DATA_W-1:0]   reg_rdata;
  logic                           scl;
  logic                           sda;
  ibesf_pkg::ibesf_flags_t        flags;
  logic                           irq;
  int                             failures = 0;
  int                             total_checks = 0;
  int                             seed = 67134;
  logic [8:0]                     v;

  // Clock 40 MHz
  always #12.5 sys_clk = ~sys_clk;

  ibesf_bus_model u_bus (.sys_clk(sys_clk), .clock_line_pin(scl), .data_line_pin(sda));

  ibesf_top DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clock_line_pin(scl),
    .data_line_pin(sda), .bus_event_status(flags), .irq(irq));

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Expected flag byte
  function automatic logic [7:0] fl(input logic a, input logic s, input logic p);
    logic [7:0] r;
    r = ibesf_pkg::RDATA_RST;
    r[ibesf_pkg::FLAG_ACK_BIT]   = a;
    r[ibesf_pkg::FLAG_START_BIT] = s;
    r[ibesf_pkg::FLAG_STOP_BIT]  = p;
    return r;
  endfunction : fl

  // One cycle write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // One cycle read, data checked in the cycle after
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  // Verdict and end
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // Watchdog
  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd(ibesf_pkg::OFS_CTRL, 8'h00);
    rd(ibesf_pkg::OFS_IRQ_MASK, 8'h00);
    rd(4'hf, 8'h00);
    u_bus.start_c();
    u_bus.stop_c();
    rd(ibesf_pkg::OFS_STATUS, fl(0, 0, 0)); // disabled no events
    chk({5'h00, flags}, fl(0, 0, 0)); // flags port idle
    $display("test reset done");
    wr(ibesf_pkg::OFS_CTRL, 8'h80);
    rd(ibesf_pkg::OFS_CTRL, 8'h80);
    u_bus.start_c();
    rd(ibesf_pkg::OFS_STATUS, fl(0, 1, 0)); // start seen
    chk({5'h00, flags}, fl(0, 1, 0)); // flags port start
    v = {$random(seed), 1'b0};
    u_bus.send(v, 9);
    rd(ibesf_pkg::OFS_STATUS, fl(1, 1, 0)); // ack seen
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      u_bus.send(v, 1);
      rd(ibesf_pkg::OFS_STATUS, fl(0, 0, 0)); // first clock clears
      u_bus.send(v << 1, 8);
      rd(ibesf_pkg::OFS_STATUS, fl(~v[0], 0, 0)); // ack per byte
    end
    u_bus.send({$random(seed), 1'b0}, 9);
    u_bus.stop_c();
    rd(ibesf_pkg::OFS_STATUS, fl(0, 0, 1)); // stop seen
    chk({5'h00, flags}, fl(0, 0, 1)); // flags port stop
    wr(ibesf_pkg::OFS_CTRL, 8'hc0);
    rd(ibesf_pkg::OFS_STATUS, fl(0, 0, 1)); // exit keeps stop
    wr(ibesf_pkg::OFS_STATUS, 8'hff);
    rd(ibesf_pkg::OFS_STATUS, fl(0, 0, 1)); // write ignored
    u_bus.start_c();
    rd(ibesf_pkg::OFS_STATUS, fl(0, 1, 1)); // stop held
    chk({5'h00, flags}, fl(0, 1, 1)); // flags port held
    u_bus.send(9'h0a0, 1);
    rd(ibesf_pkg::OFS_STATUS, fl(0, 1, 0)); // stop cleared
    u_bus.send(9'h140, 8);
    rd(ibesf_pkg::OFS_STATUS, fl(1, 1, 0)); // ack again
    $display("test transfer done");
    wr(ibesf_pkg::OFS_CTRL, 8'hc0);
    rd(ibesf_pkg::OFS_STATUS, fl(0, 0, 0)); // exit clears ack
    chk({5'h00, flags}, fl(0, 0, 0)); // exit clears start
    u_bus.stop_c();
    rd(ibesf_pkg::OFS_STATUS, fl(0, 0, 1)); // stop after exit
    wr(ibesf_pkg::OFS_CTRL, 8'h00);
    rd(ibesf_pkg::OFS_STATUS, fl(0, 0, 0)); // disable clears
    $display("test exit and disable done");
    wr(ibesf_pkg::OFS_CTRL, 8'h80);
    wr(ibesf_pkg::OFS_IRQ_STAT, 8'h07);
    rd(ibesf_pkg::OFS_IRQ_STAT, 8'h00);
    u_bus.start_c();
    u_bus.stop_c();
    rd(ibesf_pkg::OFS_IRQ_STAT, fl(0, 1, 1));
    chk({7'h00, irq}, 8'h00);
    wr(ibesf_pkg::OFS_IRQ_MASK, 8'h02);
    rd(ibesf_pkg::OFS_IRQ_MASK, 8'h02);
    chk({7'h00, irq}, 8'h01);
    wr(ibesf_pkg::OFS_IRQ_MASK, 8'h04);
    rd(ibesf_pkg::OFS_IRQ_MASK, 8'h04);
    chk({7'h00, irq}, 8'h00);
    wr(ibesf_pkg::OFS_IRQ_MASK, 8'h07);
    wr(ibesf_pkg::OFS_IRQ_STAT, 8'h03);
    rd(ibesf_pkg::OFS_IRQ_STAT, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("test interrupt done");
    u_bus.start_c();
    rd(ibesf_pkg::OFS_STATUS, fl(0, 1, 1)); // stop held over start
    // Mid-run reset with start and stop flags set
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ibesf_pkg::OFS_STATUS, fl(0, 0, 0)); // reset clears flags
    chk({5'h00, flags}, fl(0, 0, 0)); // flags port after reset
    rd(ibesf_pkg::OFS_CTRL, 8'h00);
    chk({7'h00, irq}, 8'h00);
    u_bus.stop_c();
    rd(ibesf_pkg::OFS_STATUS, fl(0, 0, 0)); // no events after reset
    $display("test mid-run reset done");
    stop_test();
  end
endmodule : ibesf_top_test
